// File: core/acqs_sequencer.sv
// Purpose: two-level acquisition / frame start trigger sequencer
// Assumes: one clock, registers reached over a plain strobe port
// Notes:   leaves reset waiting for acquisition start
// Notes on behaviour
// - line 1 rising edge moves waiting-acquisition to waiting-frame
// - software acquisition command moves waiting-acquisition to waiting-frame
// - after burst-length frames, return to waiting for acquisition start
// - while waiting for acquisition start, no frame is acquired
// - frame triggering off: frame starts made internally at programmed rate
// - rate setting off: internal frame starts as fast as possible
// - frame start events act only while waiting for frame start
// - frame start events outside waiting-frame are dropped
// - both triggers off: both events internal, continuous acquisition
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acqs_defs.svh"
module acqs_sequencer #(
  parameter int          N_LINES    = 1,
  parameter logic [31:0] PERIOD_RST = `ACQS_PERIOD_RST
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               ce,
  // register port
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wr_data,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic      [31:0]        rd_data,
  // trigger pins
  input  wire logic [N_LINES-1:0] line_in,
  // acquisition status
  output logic                    frame_start,
  output logic                    frame_active,
  output logic                    wait_acq,
  output logic                    wait_frm
);

  localparam logic [15:0] FRAME_LAST = 16'(`ACQS_FRAME_CYC - 1);

  acqs_evt_if #(.N_LINES(N_LINES)) evt ();

  acqs_line_edge #(.N_LINES(N_LINES)) u_edge (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .line_in (line_in),
    .evt     (evt.edge_mp)
  );

  acqs_rate_gen u_rate (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .evt  (evt.rate_mp)
  );

  // register file
  logic [`ACQS_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [15:0]             burst_q, burst_d;
  logic [31:0]             period_q, period_d;
  logic                    sw_acq_q, sw_acq_d;
  logic                    sw_frm_q, sw_frm_d;
  logic [15:0]             disc_q, disc_d;
  logic [31:0]             rd_data_q, rd_data_d;

  // sequencer
  acqs_pkg::acqs_state_e   state_q, state_d;
  acqs_pkg::acqs_count_t   cnt_q, cnt_d;
  logic [15:0]             tmr_q, tmr_d;
  logic                    start_q, start_d;
  logic                    active_q, active_d;
  logic                    wait_acq_q, wait_acq_d;
  logic                    wait_frm_q, wait_frm_d;

  logic                    acq_en, acq_sw, acq_fall;
  logic                    frm_en, frm_sw, frm_fall, rate_en;
  logic                    acq_evt, frm_ext_evt, frm_evt;
  logic [15:0]             burst_eff;
  logic [15:0]             cnt_inc;
  logic                    wr_cmd, wr_disc;

  assign acq_en   = ctrl_q[`ACQS_CTRL_ACQ_EN];
  assign acq_sw   = ctrl_q[`ACQS_CTRL_ACQ_SW];
  assign acq_fall = ctrl_q[`ACQS_CTRL_ACQ_FALL];
  assign frm_en   = ctrl_q[`ACQS_CTRL_FRM_EN];
  assign frm_sw   = ctrl_q[`ACQS_CTRL_FRM_SW];
  assign frm_fall = ctrl_q[`ACQS_CTRL_FRM_FALL];
  assign rate_en  = ctrl_q[`ACQS_CTRL_RATE_EN];

  assign evt.rate_en = rate_en & ~frm_en;
  assign evt.period  = period_q;

  assign wr_cmd  = wr_en && (addr == `ACQS_REG_CMD);
  assign wr_disc = wr_en && (addr == `ACQS_REG_DISCARD);

  // event selection; line 1 is bit 0 of line_in
  always_comb begin
    if (!acq_en) begin
      acq_evt = 1'b1;
    end else if (acq_sw) begin
      acq_evt = sw_acq_q;
    end else begin
      acq_evt = acq_fall ? evt.fall[0] : evt.rise[0];
    end
    if (frm_sw) begin
      frm_ext_evt = frm_en & sw_frm_q;
    end else begin
      frm_ext_evt = frm_en & (frm_fall ? evt.fall[0] : evt.rise[0]);
    end
    if (frm_en) begin
      frm_evt = frm_ext_evt;
    end else if (rate_en) begin
      frm_evt = evt.tick;
    end else begin
      frm_evt = 1'b1;
    end
  end

  // registers written by software
  always_comb begin
    ctrl_d   = ctrl_q;
    burst_d  = burst_q;
    period_d = period_q;
    sw_acq_d = wr_cmd & wr_data[`ACQS_CMD_ACQ];
    sw_frm_d = wr_cmd & wr_data[`ACQS_CMD_FRM];
    disc_d   = disc_q;
    if (wr_en) begin
      unique case (addr)
        `ACQS_REG_CTRL:   ctrl_d   = wr_data[`ACQS_CTRL_W-1:0];
        `ACQS_REG_BURST:  burst_d  = wr_data[15:0];
        `ACQS_REG_PERIOD: period_d = wr_data;
        default: ;
      endcase
    end
    // a write to the discard register clears the drop counter; a drop in the same cycle still counts
    if (wr_disc) begin
      disc_d = 16'h0000;
    end
    if (frm_ext_evt && state_q != acqs_pkg::ST_WAIT_FRM && !(&disc_q && !wr_disc)) begin
      disc_d = (wr_disc ? 16'h0000 : disc_q) + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q   <= `ACQS_CTRL_RST;
      burst_q  <= `ACQS_BURST_RST;
      period_q <= 32'h0000_0000;
      sw_acq_q <= 1'b0;
      sw_frm_q <= 1'b0;
      disc_q   <= 16'h0000;
    end else if (ce) begin
      ctrl_q   <= ctrl_d;
      burst_q  <= burst_d;
      period_q <= period_d;
      sw_acq_q <= sw_acq_d;
      sw_frm_q <= sw_frm_d;
      disc_q   <= disc_d;
    end
  end

  // burst length zero behaves as one
  assign burst_eff = (burst_q == 16'h0000) ? 16'h0001 : burst_q;
  assign cnt_inc   = cnt_q + 16'h0001;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    tmr_d   = tmr_q;
    start_d = 1'b0;
    unique case (state_q)
      acqs_pkg::ST_WAIT_ACQ: begin
        // frame events are not looked at here
        if (acq_evt) begin
          state_d = acqs_pkg::ST_WAIT_FRM;
          cnt_d   = 16'h0000;
        end
      end
      acqs_pkg::ST_WAIT_FRM: begin
        if (frm_evt) begin
          state_d = acqs_pkg::ST_EXPOSE;
          tmr_d   = FRAME_LAST;
          start_d = 1'b1;
        end
      end
      acqs_pkg::ST_EXPOSE: begin
        if (tmr_q == 16'h0000) begin
          cnt_d = cnt_inc;
          if (cnt_inc >= burst_eff) begin
            state_d = acqs_pkg::ST_WAIT_ACQ;
          end else begin
            state_d = acqs_pkg::ST_WAIT_FRM;
          end
        end else begin
          tmr_d = tmr_q - 16'h0001;
        end
      end
    endcase
    active_d   = (state_d == acqs_pkg::ST_EXPOSE);
    wait_acq_d = (state_d == acqs_pkg::ST_WAIT_ACQ);
    wait_frm_d = (state_d == acqs_pkg::ST_WAIT_FRM);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q    <= acqs_pkg::ST_WAIT_ACQ;
      cnt_q      <= 16'h0000;
      tmr_q      <= 16'h0000;
      start_q    <= 1'b0;
      active_q   <= 1'b0;
      wait_acq_q <= 1'b1;
      wait_frm_q <= 1'b0;
    end else if (ce) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      tmr_q      <= tmr_d;
      start_q    <= start_d;
      active_q   <= active_d;
      wait_acq_q <= wait_acq_d;
      wait_frm_q <= wait_frm_d;
    end
  end

  // read port: data stand only in the cycle after the strobe
  always_comb begin
    rd_data_d = 32'h0000_0000;
    if (rd_en) begin
      unique case (addr)
        `ACQS_REG_CTRL:    rd_data_d = {25'h000_0000, ctrl_q};
        `ACQS_REG_BURST:   rd_data_d = {16'h0000, burst_q};
        `ACQS_REG_PERIOD:  rd_data_d = period_q;
        `ACQS_REG_STATUS: begin
          rd_data_d[`ACQS_STAT_WAIT_ACQ] = wait_acq_q;
          rd_data_d[`ACQS_STAT_WAIT_FRM] = wait_frm_q;
          rd_data_d[`ACQS_STAT_ACTIVE]   = active_q;
          rd_data_d[`ACQS_STAT_CNT_LSB+:16] = cnt_q;
        end
        `ACQS_REG_DISCARD: rd_data_d = {16'h0000, disc_q};
        default:           rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_q <= 32'h0000_0000;
    end else if (ce) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data      = rd_data_q;
  assign frame_start  = start_q;
  assign frame_active = active_q;
  assign wait_acq     = wait_acq_q;
  assign wait_frm     = wait_frm_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_LINE_ACQ: assert property (
    wait_acq_q && acq_en && !acq_sw && !acq_fall && evt.rise[0] && ce |=> wait_frm_q)
    else $error("line 1 rising edge did not start acquisition");

  AST_SW_ACQ: assert property (
    wait_acq_q && acq_en && acq_sw && sw_acq_q && ce |=> wait_frm_q && !wait_acq_q)
    else $error("software command did not start acquisition");

  AST_BURST_END: assert property (
    state_q == acqs_pkg::ST_EXPOSE && tmr_q == 16'h0000 && cnt_inc >= burst_eff && ce
    |=> wait_acq_q && !active_q)
    else $error("burst complete but not back to waiting for acquisition");

  AST_IDLE_NO_FRAME: assert property (
    wait_acq_q |=> !frame_start && !active_q)
    else $error("frame started while waiting for acquisition start");

  AST_RATE_FRAME: assert property (
    wait_frm_q && !frm_en && rate_en && evt.tick && ce |=> frame_start ##1 (active_q || !ce))
    else $error("internal rate tick did not start a frame");

  AST_MAX_RATE: assert property (
    wait_frm_q && !frm_en && !rate_en && ce |=> frame_start && active_q)
    else $error("free frame start not taken at once");

  AST_ONLY_WAIT_FRM: assert property (
    // a pulse held frozen by ce low is not a new start
    frame_start && $past(ce) |-> $past(wait_frm_q))
    else $error("frame start outside waiting for frame start");

  AST_DROP_COUNT: assert property (
    frm_ext_evt && !wait_frm_q && !wr_disc && !(&disc_q) && ce
    |=> disc_q == $past(disc_q) + 16'h0001 && !frame_start)
    else $error("frame event outside waiting state not dropped and counted");

  AST_FREE_RUN: assert property (
    wait_acq_q && !acq_en && !frm_en && !rate_en && !wr_en && ce ##1 ce
    |=> frame_start)
    else $error("free run did not start a frame within two cycles");

  CVR_BURST_DONE: cover property (
    state_q == acqs_pkg::ST_EXPOSE ##1 wait_acq_q && burst_q > 16'h0001);
  CVR_DROP:       cover property (frm_ext_evt && wait_acq_q);
  CVR_SW_START:   cover property (sw_acq_q && wait_acq_q && acq_en && acq_sw);
  CVR_RATE_TICK:  cover property (evt.tick && wait_frm_q);

endmodule
`default_nettype wire

// File: core/acqs_defs.svh
// Purpose: register map, field positions, reset values and timing counts of the trigger sequencer
// Assumes: byte addresses on an 8-bit address port, 32-bit data
// Notes:   definitions only
`ifndef ACQS_DEFS_SVH
`define ACQS_DEFS_SVH

// register byte addresses
`define ACQS_REG_CTRL        8'h00
`define ACQS_REG_BURST       8'h04
`define ACQS_REG_PERIOD      8'h08
`define ACQS_REG_CMD         8'h0C
`define ACQS_REG_STATUS      8'h10
`define ACQS_REG_DISCARD     8'h14

// control register fields
`define ACQS_CTRL_ACQ_EN     0
`define ACQS_CTRL_ACQ_SW     1
`define ACQS_CTRL_ACQ_FALL   2
`define ACQS_CTRL_FRM_EN     3
`define ACQS_CTRL_FRM_SW     4
`define ACQS_CTRL_FRM_FALL   5
`define ACQS_CTRL_RATE_EN    6
`define ACQS_CTRL_W          7

// command register fields (write only, self clearing)
`define ACQS_CMD_ACQ         0
`define ACQS_CMD_FRM         1

// status register fields
`define ACQS_STAT_WAIT_ACQ   0
`define ACQS_STAT_WAIT_FRM   1
`define ACQS_STAT_ACTIVE     2
`define ACQS_STAT_CNT_LSB    16

// reset values of ctrl and burst; period_q resets to zero, not to ACQS_PERIOD_RST
`define ACQS_CTRL_RST        7'h03
`define ACQS_BURST_RST       16'h0001
`define ACQS_PERIOD_RST      32'h0000_2710

// shortest exposure plus readout, which sets the highest frame rate
`define ACQS_CLK_PERIOD_NS   10
`define ACQS_FRAME_MIN_NS    1000
`define ACQS_FRAME_CYC       ((`ACQS_FRAME_MIN_NS + `ACQS_CLK_PERIOD_NS - 1) / `ACQS_CLK_PERIOD_NS)

`endif

// File: core/acqs_pkg.sv
// Purpose: shared types of the trigger sequencer
// Assumes: nothing
// Notes:   constants live in acqs_defs.svh
`default_nettype none
package acqs_pkg;

  typedef enum logic [1:0] {
    ST_WAIT_ACQ,
    ST_WAIT_FRM,
    ST_EXPOSE
  } acqs_state_e;

  typedef logic [15:0] acqs_count_t;

endpackage
`default_nettype wire

// File: core/acqs_evt_if.sv
// Purpose: carries trigger events and rate settings between the sequencer's own modules
// Assumes: all three modules share one clock
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
interface acqs_evt_if #(
  parameter int N_LINES = 1
);
  logic [N_LINES-1:0] rise;
  logic [N_LINES-1:0] fall;
  logic               tick;
  logic               rate_en;
  logic [31:0]        period;

  modport edge_mp (output rise, output fall);
  modport rate_mp (input rate_en, input period, output tick);
  modport core_mp (input rise, input fall, input tick, output rate_en, output period);
endinterface
`default_nettype wire

// File: core/acqs_line_edge.sv
// Purpose: synchronise input lines and turn each edge into a one-cycle event
// Assumes: lines are asynchronous to clk
// Notes:   three cycles from pin to event
`timescale 1ns/1ps
`default_nettype none
module acqs_line_edge #(
  parameter int N_LINES = 1
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               ce,
  // pins
  input  wire logic [N_LINES-1:0] line_in,
  // events
  acqs_evt_if.edge_mp             evt
);

  for (genvar i = 0; i < N_LINES; i++) begin : g_line
    logic meta_q, sync_q, prev_q, rise_q, fall_q;
    logic meta_d, sync_d, prev_d, rise_d, fall_d;

    // meta_q feeds sync_q only
    always_comb begin
      meta_d = line_in[i];
      sync_d = meta_q;
      prev_d = sync_q;
      rise_d = sync_q & ~prev_q;
      fall_d = ~sync_q & prev_q;
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        prev_q <= 1'b0;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else if (ce) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
        prev_q <= prev_d;
        rise_q <= rise_d;
        fall_q <= fall_d;
      end
    end

    assign evt.rise[i] = rise_q;
    assign evt.fall[i] = fall_q;

    AST_EDGE_SINGLE: assert property (@(posedge clk) disable iff (srst)
      (rise_q || fall_q) && ce |=> !(rise_q || fall_q))
      else $error("line edge event longer than one cycle");
  end

endmodule
`default_nettype wire

// File: core/acqs_rate_gen.sv
// Purpose: internal frame-start tick at a programmed period
// Assumes: period counted in clk cycles, zero treated as one
// Notes:   counter idles at zero while disabled
`timescale 1ns/1ps
`default_nettype none
module acqs_rate_gen (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire logic   ce,
  // settings in, tick out
  acqs_evt_if.rate_mp evt
);

  logic [31:0] cnt_q, cnt_d;
  logic        tick_q, tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!evt.rate_en) begin
      cnt_d = 32'h0000_0000;
    end else if (cnt_q + 32'h0000_0001 >= evt.period) begin
      cnt_d  = 32'h0000_0000;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign evt.tick = tick_q;

endmodule
`default_nettype wire

// File: verif/acqs_trig_src.sv
// Purpose: far-side trigger source driving line 1 of the sequencer
// Assumes: one request pulse per trigger, line idles low between triggers
// Notes:   requests that arrive while a pulse is still out are dropped
`timescale 1ns/1ps
`default_nettype none
module acqs_trig_src #(
  parameter int HOLD_CYC = 20
) (
  // clock
  input  wire logic clk,
  // request from bench
  input  wire logic fire,
  // trigger pin
  output logic      line
);
  int cnt_q = 0;

  // long high level so each edge is seen after synchronising
  always @(posedge clk) begin
    if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end else if (fire) begin
      cnt_q <= HOLD_CYC;
    end
    line <= (cnt_q > 1) || (cnt_q == 0 && fire);
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for the trigger sequencer
// Assumes: register map and field positions from acqs_defs.svh
// Notes:   frame starts counted by a monitor process beside the tests
`timescale 1ns/1ps
`default_nettype none
`include "acqs_defs.svh"
module tb_top;
  logic        clk;
  logic        srst;
  logic        ce;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        line;
  logic        fire;
  logic        frame_start;
  logic        frame_active;
  logic        wait_acq;
  logic        wait_frm;
  logic        fs_clr;
  int          fs_cnt = 0;
  int          fs_gap = 0;
  int          cyc = 0;
  int          fs_last = 0;
  int          err_total;
  int          n_compared;

  acqs_sequencer u_dut (
    .clk          (clk),
    .srst         (srst),
    .ce           (ce),
    .addr         (addr),
    .wr_data      (wr_data),
    .wr_en        (wr_en),
    .rd_en        (rd_en),
    .rd_data      (rd_data),
    .line_in      (line),
    .frame_start  (frame_start),
    .frame_active (frame_active),
    .wait_acq     (wait_acq),
    .wait_frm     (wait_frm)
  );

  acqs_trig_src u_src (
    .clk  (clk),
    .fire (fire),
    .line (line)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // gap is the cycle distance between the last two frame starts
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fs_clr) begin
      fs_cnt <= 0;
    end else if (frame_start === 1'b1) begin
      fs_cnt  <= fs_cnt + 1;
      fs_gap  <= cyc - fs_last;
      fs_last <= cyc;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic pulse();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  // sel: 0 wait_acq, 1 wait_frm, 2 frame over, 3 frame running
  task automatic wait_sig(input int sel, input int lim);
    logic hit;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      hit = (sel == 0) ? wait_acq : (sel == 1) ? wait_frm : (sel == 2) ? !frame_active : frame_active;
      if (hit === 1'b1) begin
        return;
      end
    end
    chk("wait_timeout", 32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic clear_count();
    @(posedge clk);
    fs_clr <= 1'b1;
    @(posedge clk);
    fs_clr <= 1'b0;
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #500us;
    err_total++;
    conclude();
  end

  initial begin
    logic [31:0] d;
    srst = 1'b1;
    ce = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fire = 1'b0;
    fs_clr = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // reset values and an unmapped place
    rd(`ACQS_REG_CTRL, d); chk("ctrl", 32'h0000_0003, d);
    rd(`ACQS_REG_BURST, d); chk("burst", 32'h0000_0001, d);
    rd(`ACQS_REG_PERIOD, d); chk("period", 32'h0000_0000, d);
    rd(`ACQS_REG_CMD, d); chk("cmd", 32'h0000_0000, d);
    rd(`ACQS_REG_STATUS, d); chk("status", 32'h0000_0001, d);
    rd(8'h18, d); chk("unmapped", 32'h0000_0000, d);
    chk("frame_active", 32'h0000_0000, {31'h0, frame_active});
    $display("test reset done");
    // line-started burst of three, internal starts at top speed
    wr(`ACQS_REG_CTRL, 32'h0000_0001);
    wr(`ACQS_REG_BURST, 32'h0000_0003);
    clear_count();
    pulse();
    wait_sig(1, 20);
    chk("wait_frm", 32'h0000_0001, {31'h0, wait_frm});
    wait_sig(0, 800);
    chk("frames", 32'h0000_0003, fs_cnt);
    chk("fast_gap", 32'h0000_0001, {31'h0, fs_gap >= 100 && fs_gap <= 104});
    repeat (400) @(posedge clk);
    chk("frames_idle", 32'h0000_0003, fs_cnt);
    $display("test line burst done");
    // software start, internal starts at programmed period
    wr(`ACQS_REG_PERIOD, 32'h0000_012C);
    wr(`ACQS_REG_CTRL, 32'h0000_0043);
    clear_count();
    wr(`ACQS_REG_CMD, 32'h0000_0001);
    wait_sig(1, 5);
    wait_sig(0, 1500);
    chk("frames", 32'h0000_0003, fs_cnt);
    chk("rate_gap", 32'h0000_012C, fs_gap);
    $display("test rate burst done");
    // software start, line frame starts, drops counted
    wr(`ACQS_REG_CTRL, 32'h0000_000B);
    wr(`ACQS_REG_DISCARD, 32'h0000_0000);
    clear_count();
    pulse();
    repeat (30) @(posedge clk);
    chk("frames_early", 32'h0000_0000, fs_cnt);
    wr(`ACQS_REG_CMD, 32'h0000_0001);
    wait_sig(1, 5);
    for (int i = 0; i < 3; i++) begin
      pulse();
      wait_sig(3, 20);
      if (i == 0) begin
        repeat (25) @(posedge clk);
        pulse();
      end
      wait_sig(2, 200);
      repeat (25) @(posedge clk);
    end
    chk("wait_acq", 32'h0000_0001, {31'h0, wait_acq});
    chk("frames", 32'h0000_0003, fs_cnt);
    pulse();
    repeat (30) @(posedge clk);
    chk("frames_late", 32'h0000_0003, fs_cnt);
    rd(`ACQS_REG_DISCARD, d); chk("discard", 32'h0000_0003, d);
    $display("test line frames done");
    // falling-edge start, software frame command, burst zero acts as one
    wr(`ACQS_REG_CTRL, 32'h0000_001D);
    wr(`ACQS_REG_BURST, 32'h0000_0000);
    clear_count();
    wr(`ACQS_REG_CMD, 32'h0000_0002);
    pulse();
    repeat (10) @(posedge clk);
    #1;
    chk("rise_ignored", 32'h0000_0001, {31'h0, wait_acq});
    wait_sig(1, 30);
    chk("fall_start", 32'h0000_0001, {31'h0, wait_frm});
    wr(`ACQS_REG_CMD, 32'h0000_0002);
    wait_sig(0, 150);
    chk("frames_one", 32'h0000_0001, fs_cnt);
    rd(`ACQS_REG_DISCARD, d); chk("discard_cmd", 32'h0000_0004, d);
    wr(`ACQS_REG_BURST, 32'h0000_0003);
    $display("test software frame done");
    // both triggers off: continuous beyond the burst length
    wr(`ACQS_REG_CTRL, 32'h0000_0000);
    clear_count();
    repeat (1000) @(posedge clk);
    chk("free_run", 32'h0000_0001, {31'h0, fs_cnt >= 9 && fs_cnt <= 10});
    rd(`ACQS_REG_STATUS, d); chk("not_wait_acq", 32'h0000_0000, {31'h0, d[0]});
    $display("test free run done");
    conclude();
  end
endmodule
`default_nettype wire
